// ==== core/conv_evt_regs.vh ====
// Register offsets, field positions, reset values and event indices of the event flags
`ifndef CONV_EVT_REGS_VH
`define CONV_EVT_REGS_VH

// ==========================================================
// Register offsets (8-bit registers, 8-bit address)
`define PRBS_ENABLE_OFF 8'h20
`define CONV0_ENABLE_OFF 8'h21
`define CONV1_ENABLE_OFF 8'h22
`define CLOCK_ENABLE_OFF 8'h23
`define PRBS_STATUS_OFF 8'h24
`define CONV0_STATUS_OFF 8'h25
`define CONV1_STATUS_OFF 8'h26
`define CLOCK_STATUS_OFF 8'h27
`define PRBS_ROUTE_OFF 8'h29
`define CONV0_ROUTE_OFF 8'h2A
`define CONV1_ROUTE_OFF 8'h2B
`define CLOCK_ROUTE_OFF 8'h2C
`define SUMMARY_STATUS_OFF 8'h30
`define SUMMARY_MASK_OFF 8'h31

// ==========================================================
// Bit positions within the enable, status and route registers
`define PRBS_BIT 0
`define CAL_DONE_BIT 3
`define AMP_ERR_BIT 0
`define DLL_LOST_BIT 5
`define DLL_LOCK_BIT 4
`define PLL_LOST_BIT 1
`define PLL_LOCK_BIT 0

// ==========================================================
// Event indices in the internal event vectors
`define NUM_EVENTS 9
`define EV_PRBS 0
`define EV_C0_CAL 1
`define EV_C0_AMP 2
`define EV_C1_CAL 3
`define EV_C1_AMP 4
`define EV_DLL_LOST 5
`define EV_DLL_LOCK 6
`define EV_PLL_LOST 7
`define EV_PLL_LOCK 8

// ==========================================================
// Summary interrupt bits (one per status register group)
`define SUM_PRBS_BIT 0
`define SUM_CONV0_BIT 1
`define SUM_CONV1_BIT 2
`define SUM_CLOCK_BIT 3
`define SUM_WIDTH 4

// ==========================================================
// Reset values
`define ENABLE_RESET 9'h000
`define ROUTE_RESET 9'h000
`define SUMMARY_RESET 4'h0
`define MASK_RESET 4'h0
`define PIN_RELEASED 2'h3

`endif

// ==== core/event_flag_cell.v ====
// One event flag: live view while disabled, latched with write-one clear while enabled
`timescale 1ns/1ps

module event_flag_cell (
	// Clock and reset
	input wire sys_clk,
	input wire rst,
	// Event source and control
	input wire condition,
	input wire enable,
	input wire clearReq,
	// Flag state
	output wire flag,
	output wire latched,
	output wire latchPulse
);

	reg latched_q;
	wire latched_d;

	// ==========================================================
	// Latch
	// A condition present in the clearing cycle keeps the flag set
	assign latched_d = enable & (condition | (latched_q & ~clearReq)); // see RULE2 see RULE3

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			latched_q <= 1'b0; // see RULE14
		end else begin
			latched_q <= latched_d;
		end
	end

	// ==========================================================
	// Reported state
	// Disabled: live view; a clear write cannot touch it
	assign flag = enable ? latched_q : condition; // see RULE1 see RULE15
	assign latched = latched_q;
	assign latchPulse = enable & condition & ~latched_q;

endmodule // event_flag_cell

// ==== core/converter_event_status_flags.v ====
// Event status flags, enables, pin routing and summary interrupt of the dual converter
`timescale 1ns/1ps
`include "conv_evt_regs.vh"

// Summary of operation
// RULE1: With its enable clear, the real-channel PRBS flag shows the live converter zero error.
// RULE2: With its enable set, the PRBS flag latches and pulls its selected interrupt pin low.
// RULE3: Writing one to a latched flag clears it and releases its pin drive; the code keeps it set while its condition is still present.
// RULE4: Converter zero calibration done is bit 3 of 0x025, live or latched by its enable.
// RULE5: Converter zero amplifier protection error is bit 0 of 0x025, live or latched.
// RULE6: Converter one calibration done is bit 3 of 0x026, gated by its own enable.
// RULE7: Converter one amplifier protection error is bit 0 of 0x026, live or latched.
// RULE8: DLL lock lost is bit 5 of 0x027, live or latched by its enable.
// RULE9: DLL lock achieved is bit 4 of 0x027, live or latched by its enable.
// RULE10: Converter clock PLL lock lost is bit 1 of 0x027, live or latched by its enable.
// RULE11: Each event has its own enable bit at the matching position, all reset to zero.
// RULE12: A per-event route bit chooses which interrupt pin an enabled event drives.
// RULE13: A route value of zero sends the event to the first interrupt pin.
// RULE14: Reserved bits read zero, flags reset to zero, a pin is low while a routed flag is set.
// RULE15: Writing zero leaves a flag alone, and writing one to an unlatched flag does nothing.

module converter_event_status_flags (
	// Clock and reset
	input wire sys_clk,
	input wire rst,
	// Register port
	input wire [7:0] regAddr,
	input wire [7:0] regWrData,
	input wire regWrEn,
	input wire regRdEn,
	output wire [7:0] regRdData,
	// Event conditions, synchronous to sys_clk
	input wire realPrbsError,
	input wire conv0CalibrationDone,
	input wire conv0AmpProtectError,
	input wire conv1CalibrationDone,
	input wire conv1AmpProtectError,
	input wire dllLockLost,
	input wire dllLocked,
	input wire pllLockLost,
	input wire pllLocked,
	// Interrupt outputs
	output wire [1:0] interruptOutN,
	output wire irq
);

	// ==========================================================
	// Functions
	function hit;
		input [7:0] addr;
		input [7:0] offset;
		begin
			hit = (addr == offset);
		end
	endfunction

	// Pull the event bits of all four register groups out of their bytes into one nine-bit vector
	function [8:0] spread;
		input [7:0] prbsByte;
		input [7:0] conv0Byte;
		input [7:0] conv1Byte;
		input [7:0] clockByte;
		begin
			spread = 9'h000;
			spread[`EV_PRBS] = prbsByte[`PRBS_BIT];
			spread[`EV_C0_CAL] = conv0Byte[`CAL_DONE_BIT];
			spread[`EV_C0_AMP] = conv0Byte[`AMP_ERR_BIT];
			spread[`EV_C1_CAL] = conv1Byte[`CAL_DONE_BIT];
			spread[`EV_C1_AMP] = conv1Byte[`AMP_ERR_BIT];
			spread[`EV_DLL_LOST] = clockByte[`DLL_LOST_BIT];
			spread[`EV_DLL_LOCK] = clockByte[`DLL_LOCK_BIT];
			spread[`EV_PLL_LOST] = clockByte[`PLL_LOST_BIT];
			spread[`EV_PLL_LOCK] = clockByte[`PLL_LOCK_BIT];
		end
	endfunction

	// Pack an event vector into the byte of one group; other bits read zero
	function [7:0] gather;
		input [8:0] ev;
		input [1:0] grp;
		begin
			gather = 8'h00;
			case (grp)
				2'h0: begin
					gather[`PRBS_BIT] = ev[`EV_PRBS];
				end
				2'h1: begin
					gather[`CAL_DONE_BIT] = ev[`EV_C0_CAL];
					gather[`AMP_ERR_BIT] = ev[`EV_C0_AMP];
				end
				2'h2: begin
					gather[`CAL_DONE_BIT] = ev[`EV_C1_CAL];
					gather[`AMP_ERR_BIT] = ev[`EV_C1_AMP];
				end
				default: begin
					gather[`DLL_LOST_BIT] = ev[`EV_DLL_LOST];
					gather[`DLL_LOCK_BIT] = ev[`EV_DLL_LOCK];
					gather[`PLL_LOST_BIT] = ev[`EV_PLL_LOST];
					gather[`PLL_LOCK_BIT] = ev[`EV_PLL_LOCK];
				end
			endcase
		end
	endfunction

	// ==========================================================
	// Declarations
	reg [8:0] evEnable_q;
	reg [8:0] evEnable_d;
	reg [8:0] evRoute_q;
	reg [8:0] evRoute_d;
	reg [`SUM_WIDTH-1:0] summary_q;
	reg [`SUM_WIDTH-1:0] summary_d;
	reg [`SUM_WIDTH-1:0] mask_q;
	reg [`SUM_WIDTH-1:0] mask_d;
	reg [1:0] pinN_q;
	reg [1:0] pinN_d;
	reg irq_q;
	reg irq_d;
	reg [7:0] rdData_q;
	reg [7:0] rdData_d;
	reg [8:0] evClear;
	wire [8:0] evCondition;
	wire [8:0] evFlag;
	wire [8:0] evLatched;
	wire [8:0] evLatchPulse;
	wire [`SUM_WIDTH-1:0] summarySet;
	wire [8:0] wrPrbs;
	wire [8:0] wrConv0;
	wire [8:0] wrConv1;
	wire [8:0] wrClock;

	assign evCondition[`EV_PRBS] = realPrbsError;
	assign evCondition[`EV_C0_CAL] = conv0CalibrationDone;
	assign evCondition[`EV_C0_AMP] = conv0AmpProtectError;
	assign evCondition[`EV_C1_CAL] = conv1CalibrationDone;
	assign evCondition[`EV_C1_AMP] = conv1AmpProtectError;
	assign evCondition[`EV_DLL_LOST] = dllLockLost;
	assign evCondition[`EV_DLL_LOCK] = dllLocked;
	assign evCondition[`EV_PLL_LOST] = pllLockLost;
	assign evCondition[`EV_PLL_LOCK] = pllLocked;

	// ==========================================================
	// Write decode
	// Each write touches the event bits of exactly one group
	assign wrPrbs = spread(regWrData, 8'h00, 8'h00, 8'h00);
	assign wrConv0 = spread(8'h00, regWrData, 8'h00, 8'h00);
	assign wrConv1 = spread(8'h00, 8'h00, regWrData, 8'h00);
	assign wrClock = spread(8'h00, 8'h00, 8'h00, regWrData);

	// Write-one clear of status bits; zeros and reserved bits are ignored
	always @* begin
		evClear = 9'h000;
		if (regWrEn) begin
			if (hit(regAddr, `PRBS_STATUS_OFF)) begin
				evClear = wrPrbs; // see RULE3
			end else if (hit(regAddr, `CONV0_STATUS_OFF)) begin
				evClear = wrConv0; // see RULE3 see RULE15
			end else if (hit(regAddr, `CONV1_STATUS_OFF)) begin
				evClear = wrConv1; // see RULE3 see RULE15
			end else if (hit(regAddr, `CLOCK_STATUS_OFF)) begin
				evClear = wrClock; // see RULE3 see RULE15
			end
		end
	end

	// ==========================================================
	// Enable registers, one bit per event at its status bit position
	always @* begin
		evEnable_d = evEnable_q;
		if (regWrEn) begin
			if (hit(regAddr, `PRBS_ENABLE_OFF)) begin
				evEnable_d = (evEnable_q & ~9'h001) | (wrPrbs & 9'h001); // see RULE11
			end else if (hit(regAddr, `CONV0_ENABLE_OFF)) begin
				evEnable_d = (evEnable_q & ~9'h006) | (wrConv0 & 9'h006); // see RULE11
			end else if (hit(regAddr, `CONV1_ENABLE_OFF)) begin
				evEnable_d = (evEnable_q & ~9'h018) | (wrConv1 & 9'h018); // see RULE11
			end else if (hit(regAddr, `CLOCK_ENABLE_OFF)) begin
				evEnable_d = (evEnable_q & ~9'h1E0) | (wrClock & 9'h1E0); // see RULE11
			end
		end
	end

	// ==========================================================
	// Route registers; a zero bit selects the first pin
	always @* begin
		evRoute_d = evRoute_q;
		if (regWrEn) begin
			if (hit(regAddr, `PRBS_ROUTE_OFF)) begin
				evRoute_d = (evRoute_q & ~9'h001) | (wrPrbs & 9'h001); // see RULE12
			end else if (hit(regAddr, `CONV0_ROUTE_OFF)) begin
				evRoute_d = (evRoute_q & ~9'h006) | (wrConv0 & 9'h006); // see RULE12
			end else if (hit(regAddr, `CONV1_ROUTE_OFF)) begin
				evRoute_d = (evRoute_q & ~9'h018) | (wrConv1 & 9'h018); // see RULE12
			end else if (hit(regAddr, `CLOCK_ROUTE_OFF)) begin
				evRoute_d = (evRoute_q & ~9'h1E0) | (wrClock & 9'h1E0); // see RULE12
			end
		end
	end

	// ==========================================================
	// Event flags
	genvar i;
	generate
		for (i = 0; i < `NUM_EVENTS; i = i + 1) begin : gFlag
			event_flag_cell uCell (
				.sys_clk(sys_clk),
				.rst(rst),
				.condition(evCondition[i]), // see RULE4 see RULE5 see RULE6 see RULE7
				.enable(evEnable_q[i]), // see RULE8 see RULE9 see RULE10
				.clearReq(evClear[i]),
				.flag(evFlag[i]),
				.latched(evLatched[i]),
				.latchPulse(evLatchPulse[i])
			);
		end
	endgenerate

	// ==========================================================
	// Interrupt pins
	// Registered so the pins never glitch on decode paths
	always @* begin
		pinN_d = `PIN_RELEASED;
		if (|(evLatched & ~evRoute_q)) begin
			pinN_d[0] = 1'b0; // see RULE13 see RULE14 see RULE2
		end
		if (|(evLatched & evRoute_q)) begin
			pinN_d[1] = 1'b0; // see RULE12 see RULE14
		end
	end

	// ==========================================================
	// Summary interrupt: one sticky bit per group, set when a flag latches
	assign summarySet[`SUM_PRBS_BIT] = evLatchPulse[`EV_PRBS];
	assign summarySet[`SUM_CONV0_BIT] = evLatchPulse[`EV_C0_CAL] | evLatchPulse[`EV_C0_AMP];
	assign summarySet[`SUM_CONV1_BIT] = evLatchPulse[`EV_C1_CAL] | evLatchPulse[`EV_C1_AMP];
	assign summarySet[`SUM_CLOCK_BIT] = |evLatchPulse[`EV_PLL_LOCK:`EV_DLL_LOST];

	// A read clears the bits it returned; a new set in that cycle survives
	always @* begin
		summary_d = summary_q;
		if (regRdEn && hit(regAddr, `SUMMARY_STATUS_OFF)) begin
			summary_d = `SUMMARY_RESET;
		end
		summary_d = summary_d | summarySet;
	end

	// Mask register, same layout as the summary status
	always @* begin
		mask_d = mask_q;
		if (regWrEn && hit(regAddr, `SUMMARY_MASK_OFF)) begin
			mask_d = regWrData[`SUM_WIDTH-1:0];
		end
	end

	// A new mask takes hold on the edge after it is written
	always @* begin
		irq_d = |(summary_d & mask_q);
	end

	// ==========================================================
	// Read path: data valid in the cycle after the strobe, zero elsewhere
	always @* begin
		rdData_d = 8'h00;
		if (regRdEn) begin
			case (regAddr)
				`PRBS_ENABLE_OFF: rdData_d = gather(evEnable_q, 2'h0);
				`CONV0_ENABLE_OFF: rdData_d = gather(evEnable_q, 2'h1);
				`CONV1_ENABLE_OFF: rdData_d = gather(evEnable_q, 2'h2);
				`CLOCK_ENABLE_OFF: rdData_d = gather(evEnable_q, 2'h3);
				`PRBS_STATUS_OFF: rdData_d = gather(evFlag, 2'h0); // see RULE1
				`CONV0_STATUS_OFF: rdData_d = gather(evFlag, 2'h1); // see RULE4 see RULE5
				`CONV1_STATUS_OFF: rdData_d = gather(evFlag, 2'h2); // see RULE6 see RULE7
				`CLOCK_STATUS_OFF: rdData_d = gather(evFlag, 2'h3); // see RULE8 see RULE9 see RULE10
				`PRBS_ROUTE_OFF: rdData_d = gather(evRoute_q, 2'h0);
				`CONV0_ROUTE_OFF: rdData_d = gather(evRoute_q, 2'h1);
				`CONV1_ROUTE_OFF: rdData_d = gather(evRoute_q, 2'h2);
				`CLOCK_ROUTE_OFF: rdData_d = gather(evRoute_q, 2'h3);
				`SUMMARY_STATUS_OFF: rdData_d = {4'h0, summary_q};
				`SUMMARY_MASK_OFF: rdData_d = {4'h0, mask_q};
				default: rdData_d = 8'h00; // see RULE14
			endcase
		end
	end

	// ==========================================================
	// Registers
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			evEnable_q <= `ENABLE_RESET; // see RULE11
			evRoute_q <= `ROUTE_RESET;
			summary_q <= `SUMMARY_RESET;
			mask_q <= `MASK_RESET;
			pinN_q <= `PIN_RELEASED;
			irq_q <= 1'b0;
			rdData_q <= 8'h00;
		end else begin
			evEnable_q <= evEnable_d;
			evRoute_q <= evRoute_d;
			summary_q <= summary_d;
			mask_q <= mask_d;
			pinN_q <= pinN_d;
			irq_q <= irq_d;
			rdData_q <= rdData_d;
		end
	end

	// ==========================================================
	// Outputs
	assign interruptOutN = pinN_q;
	assign irq = irq_q;
	assign regRdData = rdData_q;

endmodule // converter_event_status_flags

// ==== test/converter_event_status_flags_props.sv ====
// Port-level assertions for the converter event status flag block
`timescale 1ns/1ps

module converter_event_status_flags_props (
	// Clock and reset
	input logic sys_clk,
	input logic rst,
	// Register port
	input logic [7:0] regAddr,
	input logic regWrEn,
	input logic regRdEn,
	input logic [7:0] regRdData,
	// Event conditions
	input logic realPrbsError,
	input logic conv0CalibrationDone,
	input logic conv0AmpProtectError,
	input logic conv1CalibrationDone,
	input logic conv1AmpProtectError,
	input logic dllLockLost,
	input logic dllLocked,
	input logic pllLockLost
);
	// ==========================================================
	// Clocking
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// ==========================================================
	// A condition already high at the last edge, with no write there to move an enable,
	// reads one: live when disabled, already latched when enabled
	property p_prbs;
		regRdEn && regAddr == 8'h24 && realPrbsError && $past(realPrbsError) &&
			!$past(regWrEn) |=> regRdData[0];
	endproperty
	a_prbs: assert property (p_prbs) else $error("prbs flag missing");
	property p_c0cal;
		regRdEn && regAddr == 8'h25 && conv0CalibrationDone && $past(conv0CalibrationDone) &&
			!$past(regWrEn) |=> regRdData[3];
	endproperty
	a_c0cal: assert property (p_c0cal) else $error("conv0 cal flag missing");
	property p_c0amp;
		regRdEn && regAddr == 8'h25 && conv0AmpProtectError && $past(conv0AmpProtectError) &&
			!$past(regWrEn) |=> regRdData[0];
	endproperty
	a_c0amp: assert property (p_c0amp) else $error("conv0 amp flag missing");
	property p_c1cal;
		regRdEn && regAddr == 8'h26 && conv1CalibrationDone && $past(conv1CalibrationDone) &&
			!$past(regWrEn) |=> regRdData[3];
	endproperty
	a_c1cal: assert property (p_c1cal) else $error("conv1 cal flag missing");
	property p_c1amp;
		regRdEn && regAddr == 8'h26 && conv1AmpProtectError && $past(conv1AmpProtectError) &&
			!$past(regWrEn) |=> regRdData[0];
	endproperty
	a_c1amp: assert property (p_c1amp) else $error("conv1 amp flag missing");
	property p_dlllost;
		regRdEn && regAddr == 8'h27 && dllLockLost && $past(dllLockLost) &&
			!$past(regWrEn) |=> regRdData[5];
	endproperty
	a_dlllost: assert property (p_dlllost) else $error("dll lost flag missing");
	property p_dlllock;
		regRdEn && regAddr == 8'h27 && dllLocked && $past(dllLocked) &&
			!$past(regWrEn) |=> regRdData[4];
	endproperty
	a_dlllock: assert property (p_dlllock) else $error("dll lock flag missing");
	property p_plllost;
		regRdEn && regAddr == 8'h27 && pllLockLost && $past(pllLockLost) &&
			!$past(regWrEn) |=> regRdData[1];
	endproperty
	a_plllost: assert property (p_plllost) else $error("pll lost flag missing");
	property p_rsvd;
		regRdEn && regAddr == 8'h25 |=> regRdData[7:4] == 4'h0 && regRdData[2:1] == 2'h0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
	property p_unmapped;
		regRdEn && regAddr == 8'h40 |=> regRdData == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule // converter_event_status_flags_props

bind converter_event_status_flags converter_event_status_flags_props u_props (
	.sys_clk(sys_clk),
	.rst(rst),
	.regAddr(regAddr),
	.regWrEn(regWrEn),
	.regRdEn(regRdEn),
	.regRdData(regRdData),
	.realPrbsError(realPrbsError),
	.conv0CalibrationDone(conv0CalibrationDone),
	.conv0AmpProtectError(conv0AmpProtectError),
	.conv1CalibrationDone(conv1CalibrationDone),
	.conv1AmpProtectError(conv1AmpProtectError),
	.dllLockLost(dllLockLost),
	.dllLocked(dllLocked),
	.pllLockLost(pllLockLost)
);

// ==== test/test_converter_event_status_flags.sv ====
// Self-checking bench for the converter event status flag block
`timescale 1ns/1ps

module test_converter_event_status_flags;
	// ==========================================================
	// Stimulus and observation
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic regWrEn = 1'b0;
	logic regRdEn = 1'b0;
	logic [8:0] cond = 9'h000;
	wire [7:0] regRdData;
	wire [1:0] interruptOutN;
	wire irq;
	int failures = 0;
	int checks_done = 0;
	logic [7:0] statAddr [9] = '{8'h24, 8'h25, 8'h25, 8'h26, 8'h26, 8'h27, 8'h27, 8'h27, 8'h27};
	int bitPos [9] = '{0, 3, 0, 3, 0, 5, 4, 1, 0};

	converter_event_status_flags uut (
		.sys_clk(sys_clk),
		.rst(rst),
		.regAddr(regAddr),
		.regWrData(regWrData),
		.regWrEn(regWrEn),
		.regRdEn(regRdEn),
		.regRdData(regRdData),
		.realPrbsError(cond[0]),
		.conv0CalibrationDone(cond[1]),
		.conv0AmpProtectError(cond[2]),
		.conv1CalibrationDone(cond[3]),
		.conv1AmpProtectError(cond[4]),
		.dllLockLost(cond[5]),
		.dllLocked(cond[6]),
		.pllLockLost(cond[7]),
		.pllLocked(cond[8]),
		.interruptOutN(interruptOutN),
		.irq(irq)
	);

	initial forever #4 sys_clk = ~sys_clk;

	// ==========================================================
	// Shared helpers
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regWrEn <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge sys_clk);
		regWrEn <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge sys_clk);
		regRdEn <= 1'b1;
		regAddr <= a;
		@(posedge sys_clk);
		regRdEn <= 1'b0;
		#1 chk(regRdData, exp, what);
	endtask

	task automatic pulse(input int i);
		@(posedge sys_clk);
		cond[i] <= 1'b1;
		@(posedge sys_clk);
		cond[i] <= 1'b0;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		chk({6'h00, interruptOutN}, 8'h03, "pins after reset");
		chk({7'h00, irq}, 8'h00, "irq after reset");
		for (int a = 8'h20; a <= 8'h31; a++) rd(a[7:0], 8'h00, "reset value");
		rd(8'h40, 8'h00, "unmapped");
	endtask

	task automatic t_summary;
		wr(8'h21, 8'h08);
		pulse(1);
		repeat (3) @(posedge sys_clk);
		#1 chk({7'h00, irq}, 8'h00, "irq masked");
		wr(8'h31, 8'h02);
		repeat (2) @(posedge sys_clk);
		#1 chk({7'h00, irq}, 8'h01, "irq unmasked");
		rd(8'h31, 8'h02, "mask readback");
		rd(8'h30, 8'h02, "summary status");
		repeat (2) @(posedge sys_clk);
		#1 chk({7'h00, irq}, 8'h00, "irq after summary read");
		wr(8'h25, 8'h08);
		wr(8'h21, 8'h00);
		wr(8'h31, 8'h00);
	endtask

	task automatic t_live;
		logic [7:0] m;
		for (int i = 0; i < 9; i++) begin
			m = 8'h01 << bitPos[i];
			@(posedge sys_clk);
			cond[i] <= 1'b1;
			rd(statAddr[i], m, "live high");
			wr(statAddr[i], m);
			rd(statAddr[i], m, "unlatched write one");
			@(posedge sys_clk);
			cond[i] <= 1'b0;
			rd(statAddr[i], 8'h00, "live low");
			chk({6'h00, interruptOutN}, 8'h03, "pins in live mode");
		end
	endtask

	task automatic t_latch;
		logic [7:0] m;
		for (int i = 0; i < 9; i++) begin
			m = 8'h01 << bitPos[i];
			for (int r = 0; r < 2; r++) begin
				wr(statAddr[i] - 8'h04, m);
				rd(statAddr[i] - 8'h04, m, "enable readback");
				if (r == 1) wr(statAddr[i] + 8'h05, m);
				if (r == 1) rd(statAddr[i] + 8'h05, m, "route readback");
				pulse(i);
				@(posedge sys_clk);
				#1 chk({6'h00, interruptOutN}, r ? 8'h01 : 8'h02, "pin routed");
				rd(statAddr[i], m, "latched");
				wr(statAddr[i], 8'h00);
				rd(statAddr[i], m, "write zero kept");
				wr(statAddr[i], m);
				@(posedge sys_clk);
				#1 chk({6'h00, interruptOutN}, 8'h03, "pin released");
				rd(statAddr[i], 8'h00, "cleared");
				wr(statAddr[i] - 8'h04, 8'h00);
				wr(statAddr[i] + 8'h05, 8'h00);
			end
		end
	endtask

	task automatic t_reserved;
		wr(8'h25, 8'hFF);
		rd(8'h25, 8'h00, "status reserved");
		wr(8'h21, 8'hFF);
		rd(8'h21, 8'h09, "enable reserved");
		wr(8'h21, 8'h00);
	endtask

	// ==========================================================
	// Verdict
	task automatic final_report;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		t_reset;
		t_summary;
		t_live;
		t_latch;
		t_reserved;
		final_report;
	end

	// Whole run needs well under two thousand cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		$display("mismatch at %0t: watchdog expired", $time);
		final_report;
	end
endmodule // test_converter_event_status_flags
